//--- hw/adc_regs_pkg.sv
// shared constants and types of the converter status and mode register block
package adc_regs_pkg;
    // ------------------------------------------------------------
    // register select codes
    // ------------------------------------------------------------
    localparam logic [2:0] RS_STATUS = 3'h0;
    localparam logic [2:0] RS_MODE   = 3'h1;
    localparam logic [2:0] RS_CONFIG = 3'h2;
    localparam logic [2:0] RS_DATA   = 3'h3;
    localparam logic [2:0] RS_ID     = 3'h4;
    localparam logic [2:0] RS_GPO    = 3'h5;

    // ------------------------------------------------------------
    // transfer lengths in serial clocks
    // ------------------------------------------------------------
    localparam logic [5:0] LEN_BYTE = 6'h08;
    localparam logic [5:0] LEN_WORD = 6'h18;
    localparam logic [5:0] LEN_LONG = 6'h20;

    // ------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------
    localparam int CB_RW     = 6;
    localparam int CB_SEL_HI = 5;
    localparam int CB_SEL_LO = 3;

    // ------------------------------------------------------------
    // reset values, mode write mask and clamp value
    // ------------------------------------------------------------
    localparam logic [7:0]  STATUS_RESET = 8'h80;
    localparam logic [23:0] MODE_RESET   = 24'h08_0060;
    localparam logic [23:0] MODE_MASK    = 24'hFF_BFFF;
    localparam logic [23:0] DATA_CLAMP   = 24'hFF_FFFF;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int SR_READY  = 7;
    localparam int SR_ERR    = 6;
    localparam int SR_REF_MISSING = 5;
    localparam int SR_PARITY = 4;

    // ------------------------------------------------------------
    // mode field positions
    // ------------------------------------------------------------
    localparam int MR_OP_HI     = 23;
    localparam int MR_OP_LO     = 21;
    localparam int MR_APPEND    = 20;
    localparam int MR_CLK_HI    = 19;
    localparam int MR_CLK_LO    = 18;
    localparam int MR_AVG_HI    = 17;
    localparam int MR_AVG_LO    = 16;
    localparam int MR_THIRD     = 15;
    localparam int MR_ZERO      = 14;
    localparam int MR_PARITY    = 13;
    localparam int MR_CLK_DIV   = 12;
    localparam int MR_SINGLE    = 11;
    localparam int MR_NOTCH     = 10;
    localparam int MR_RATE_HI   = 9;
    localparam int MR_RATE_LO   = 0;

    // serial frame states
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_READ, ST_WRITE} frame_state_t;
endpackage

//--- hw/adc_status_and_mode_regs.sv
// serial command decode, mode register and status readout of the converter
//
// Behaviour
// - status is 8-bit read-only, select 000, resets 0x80
// - status shifts out bit 7 first
// - new result clears active-low ready bit
// - ready set after data read or pre-update warning
// - ready forced in low-power modes or sync low
// - output pin also shows ready between transfers
// - error flag set on clamped stored result
// - error clears when result back in range
// - error set on calibration faults
// - missing reference flag clamps results to ones
// - missing reference flag needs detect enable
// - parity bit shows odd ones of data
// - channel tag belongs to held result
// - mode register 24-bit, select 001, resets 0x080060
// - mode transfers most significant bit first
// - mode write resets modulator and sets ready
// - mode fields fixed layout, bit 14 zero
// - select bits choose register of next transfer
`timescale 1ns/1ps
module adc_status_and_mode_regs #(
    parameter logic [2:0] IDLE_CODE  = 3'h4,
    parameter logic [2:0] PDOWN_CODE = 3'h3
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        sclk_pin,
    input  wire logic        cs_n_pin,
    input  wire logic        din_pin,
    input  wire logic        sync_n_pin,
    input  wire logic        result_load,
    input  wire logic [23:0] result_data,
    input  wire logic        result_over,
    input  wire logic [3:0]  result_channel,
    input  wire logic        pre_update_warn,
    input  wire logic        ref_below,
    input  wire logic        ref_detect_enable,
    input  wire logic        cal_active,
    input  wire logic        cal_system,
    input  wire logic        cal_input_out_of_range,
    output logic             dout,
    output logic             dout_oe_n,
    output logic [23:0]      mode_value,
    output logic [7:0]       status_value,
    output logic             modulator_reset,
    output logic             ref_missing_flag
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    adc_regs_pkg::frame_state_t state;
    logic        cs_active;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        din_bit;
    logic [1:0]  sync_sync;
    logic [2:0]  cmd_count;
    logic [7:0]  cmd_shift;
    logic [2:0]  sel;
    logic [5:0]  bit_count;
    logic [31:0] out_shift;
    logic [23:0] in_shift;
    logic [23:0] data_value;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // serial length of the register behind a select code
    function automatic logic [5:0] reg_length(input logic [2:0] rs, input logic append);
        logic [5:0] len;
        len = adc_regs_pkg::LEN_WORD;
        case (rs)
            adc_regs_pkg::RS_STATUS: len = adc_regs_pkg::LEN_BYTE;
            adc_regs_pkg::RS_ID:     len = adc_regs_pkg::LEN_BYTE;
            adc_regs_pkg::RS_GPO:    len = adc_regs_pkg::LEN_BYTE;
            adc_regs_pkg::RS_DATA:   len = append ? adc_regs_pkg::LEN_LONG
                                                  : adc_regs_pkg::LEN_WORD;
            default:                 len = adc_regs_pkg::LEN_WORD;
        endcase
        return len;
    endfunction

    // true for the operating modes that stop conversion
    function automatic logic is_low_power(input logic [2:0] op);
        return (op == IDLE_CODE) || (op == PDOWN_CODE);
    endfunction

    // ------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------
    serial_front u_front (
        .clock     (clock),
        .resetn    (resetn),
        .sclk_pin  (sclk_pin),
        .cs_n_pin  (cs_n_pin),
        .din_pin   (din_pin),
        .cs_active (cs_active),
        .sclk_rise (sclk_rise),
        .sclk_fall (sclk_fall),
        .din_bit   (din_bit)
    );

    // sync pin synchroniser
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_sync <= 2'h3;
        end else begin
            sync_sync <= {sync_sync[0], sync_n_pin};
        end
    end

    // ------------------------------------------------------------
    // command and transfer decode
    // ------------------------------------------------------------
    wire        append     = mode_value[adc_regs_pkg::MR_APPEND];
    wire        in_cmd     = (state == adc_regs_pkg::ST_CMD) && sclk_rise;
    wire        gate_hold  = in_cmd && (cmd_count == 3'h0) && din_bit;
    wire        cmd_take   = in_cmd && !gate_hold;
    wire        cmd_done   = cmd_take && (cmd_count == 3'h7);
    wire [7:0]  cmd_byte   = {cmd_shift[6:0], din_bit};
    wire        cmd_read   = cmd_byte[adc_regs_pkg::CB_RW];
    wire [2:0]  cmd_sel    = cmd_byte[adc_regs_pkg::CB_SEL_HI:adc_regs_pkg::CB_SEL_LO];
    wire        to_comms   = !cmd_read && (cmd_sel == adc_regs_pkg::RS_STATUS);
    wire        xfer       = (state == adc_regs_pkg::ST_READ) ||
                             (state == adc_regs_pkg::ST_WRITE);
    wire        xfer_last  = xfer && sclk_rise && (bit_count == 6'h01);
    wire [23:0] next_mode  = {in_shift[22:0], din_bit} & adc_regs_pkg::MODE_MASK;
    wire        mode_write = (state == adc_regs_pkg::ST_WRITE) && xfer_last &&
                             (sel == adc_regs_pkg::RS_MODE);
    wire        data_read  = (state == adc_regs_pkg::ST_READ) && xfer_last &&
                             (sel == adc_regs_pkg::RS_DATA);
    wire        sync_low   = !sync_sync[1];
    wire        ready_set  = data_read | pre_update_warn | modulator_reset |
                             sync_low |
                             is_low_power(mode_value[adc_regs_pkg::MR_OP_HI:adc_regs_pkg::MR_OP_LO]);

    // word placed on the output shifter, first bit at the top
    logic [31:0] read_word;
    always_comb begin
        read_word = 32'h0000_0000;
        case (cmd_sel)
            adc_regs_pkg::RS_STATUS: read_word = {status_value, 24'h00_0000};
            adc_regs_pkg::RS_MODE:   read_word = {mode_value, 8'h00};
            adc_regs_pkg::RS_DATA:   read_word = append ? {data_value, status_value}
                                                        : {data_value, 8'h00};
            default:                 read_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // frame state machine
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= adc_regs_pkg::ST_IDLE;
        end else if (!cs_active) begin
            state <= adc_regs_pkg::ST_IDLE;
        end else begin
            case (state)
                adc_regs_pkg::ST_IDLE: state <= adc_regs_pkg::ST_CMD;
                adc_regs_pkg::ST_CMD: begin
                    if (cmd_done && cmd_read) begin
                        state <= adc_regs_pkg::ST_READ;
                    end else if (cmd_done && !to_comms) begin
                        state <= adc_regs_pkg::ST_WRITE;
                    end
                end
                adc_regs_pkg::ST_READ,
                adc_regs_pkg::ST_WRITE: begin
                    if (xfer_last) begin
                        state <= adc_regs_pkg::ST_CMD;
                    end
                end
                default: state <= adc_regs_pkg::ST_IDLE;
            endcase
        end
    end

    // command byte collection, gate bit held until a zero arrives
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmd_count <= 3'h0;
            cmd_shift <= 8'h00;
            sel       <= adc_regs_pkg::RS_STATUS;
        end else if (state != adc_regs_pkg::ST_CMD) begin
            cmd_count <= 3'h0;
        end else if (cmd_take) begin
            cmd_count <= cmd_count + 3'h1;
            cmd_shift <= cmd_byte;
            if (cmd_done) begin
                sel <= cmd_sel;
            end
        end
    end

    // bit counter and shifters; output changes on falling clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_count <= 6'h00;
            out_shift <= 32'h0000_0000;
            in_shift  <= 24'h00_0000;
        end else if (cmd_done) begin
            bit_count <= reg_length(cmd_sel, append);
            out_shift <= read_word;
        end else if (xfer && sclk_rise) begin
            bit_count <= bit_count - 6'h01;
            in_shift  <= {in_shift[22:0], din_bit};
        end else if ((state == adc_regs_pkg::ST_READ) && sclk_fall) begin
            out_shift <= {out_shift[30:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_value      <= adc_regs_pkg::MODE_RESET;
            modulator_reset <= 1'b0;
        end else begin
            modulator_reset <= mode_write;
            if (mode_write) begin
                mode_value <= next_mode;
            end
        end
    end

    // ------------------------------------------------------------
    // serial output and ready indication
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dout      <= 1'b1;
            dout_oe_n <= 1'b1;
        end else begin
            dout_oe_n <= !cs_active;
            if ((state == adc_regs_pkg::ST_READ) && sclk_fall) begin
                dout <= out_shift[31];
            end else if (state != adc_regs_pkg::ST_READ) begin
                dout <= status_value[adc_regs_pkg::SR_READY];
            end
        end
    end

    status_tracker u_status (
        .clock                  (clock),
        .resetn                 (resetn),
        .result_load            (result_load),
        .result_data            (result_data),
        .result_over            (result_over),
        .result_channel         (result_channel),
        .ready_set              (ready_set),
        .ref_below              (ref_below),
        .ref_detect_enable      (ref_detect_enable),
        .cal_active             (cal_active),
        .cal_system             (cal_system),
        .cal_input_out_of_range (cal_input_out_of_range),
        .parity_check_enable    (mode_value[adc_regs_pkg::MR_PARITY]),
        .status_value           (status_value),
        .data_value             (data_value),
        .ref_missing_flag       (ref_missing_flag)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_mode_write;
        mode_write && !result_load;
    endsequence

    sequence s_reset_then_ready;
        modulator_reset ##1 (status_value[7] || $past(result_load));
    endsequence

    AST_MODE_WRITE_RESETS: assert property (s_mode_write |=> s_reset_then_ready)
        else $error("mode write did not reset modulator and set ready");
    AST_MODE_ZERO_BIT: assert property (!mode_value[14])
        else $error("fixed zero bit of mode register is set");
    AST_MODE_STORES_SERIAL: assert property (
        mode_write |=> mode_value[23:15] == $past(in_shift[22:14])
            && mode_value[13:1] == $past(in_shift[12:0]))
        else $error("mode register not loaded most significant bit first");
    AST_STATUS_READ_LOAD: assert property (
        (cmd_done && cmd_read && cmd_sel == 3'h0) |=> out_shift[31:24] == $past(status_value)
            && bit_count == 6'h08)
        else $error("status read not staged as eight bits from bit 7");
    AST_STATUS_WRITE_IGNORED: assert property (
        (cmd_done && to_comms) |=> state == adc_regs_pkg::ST_CMD && $stable(mode_value))
        else $error("write to status register had an effect");
    AST_GATE_HOLDS: assert property (gate_hold |=> cmd_count == 3'h0)
        else $error("command collection advanced on a one gate bit");
    AST_SYNC_READY: assert property ((sync_low && !result_load) |=> status_value[7])
        else $error("ready not forced while sync is low");
    AST_DATA_READ_READY: assert property ((data_read && !result_load) |=> status_value[7])
        else $error("ready not set after data read");
    AST_PIN_SHOWS_READY: assert property (
        (state != adc_regs_pkg::ST_READ) |=> dout == $past(status_value[7]))
        else $error("output pin does not show ready between transfers");
    AST_RELEASE_FLOATS: assert property (!cs_active |=> dout_oe_n)
        else $error("output driven while chip select released");
    AST_SELECT_DRIVES: assert property (cs_active |=> !dout_oe_n)
        else $error("output not driven while chip select active");
endmodule

//--- hw/serial_front.sv
// pin synchroniser and edge detector of the serial port
`timescale 1ns/1ps
module serial_front (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic sclk_pin,
    input  wire logic cs_n_pin,
    input  wire logic din_pin,
    output logic      cs_active,
    output logic      sclk_rise,
    output logic      sclk_fall,
    output logic      din_bit
);
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] din_sync;
    logic       sclk_last;

    // two-stage synchronisers, idle levels high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_sync <= 2'h3;
            cs_sync   <= 2'h3;
            din_sync  <= 2'h3;
            sclk_last <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_pin};
            cs_sync   <= {cs_sync[0], cs_n_pin};
            din_sync  <= {din_sync[0], din_pin};
            sclk_last <= sclk_sync[1];
        end
    end

    // edges seen only on the second stage
    assign sclk_rise = sclk_sync[1] & ~sclk_last;
    assign sclk_fall = ~sclk_sync[1] & sclk_last;
    assign cs_active = ~cs_sync[1];
    assign din_bit   = din_sync[1];
endmodule

//--- hw/status_tracker.sv
// status flags and held conversion result
`timescale 1ns/1ps
module status_tracker (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        result_load,
    input  wire logic [23:0] result_data,
    input  wire logic        result_over,
    input  wire logic [3:0]  result_channel,
    input  wire logic        ready_set,
    input  wire logic        ref_below,
    input  wire logic        ref_detect_enable,
    input  wire logic        cal_active,
    input  wire logic        cal_system,
    input  wire logic        cal_input_out_of_range,
    input  wire logic        parity_check_enable,
    output logic [7:0]       status_value,
    output logic [23:0]      data_value,
    output logic             ref_missing_flag
);
    logic       ready_n;
    logic       err;
    logic       parity;
    logic [3:0] result_channel_tag;

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    wire        clamped   = result_over | ref_missing_flag;
    wire        cal_fault = cal_active & (ref_below | (cal_system & cal_input_out_of_range));
    wire [23:0] stored    = ref_missing_flag ? adc_regs_pkg::DATA_CLAMP : result_data;

    // flags; a new result wins over any ready set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready_n            <= adc_regs_pkg::STATUS_RESET[adc_regs_pkg::SR_READY];
            err                <= 1'b0;
            ref_missing_flag   <= 1'b0;
            parity             <= 1'b0;
            result_channel_tag <= 4'h0;
            data_value         <= 24'h00_0000;
        end else begin
            ref_missing_flag <= ref_detect_enable & ref_below;
            parity           <= parity_check_enable & (^data_value);
            if (result_load) begin
                ready_n            <= 1'b0;
                err                <= clamped | cal_fault;
                result_channel_tag <= result_channel;
                data_value         <= stored;
            end else begin
                if (ready_set) begin
                    ready_n <= 1'b1;
                end
                if (cal_fault) begin
                    err <= 1'b1;
                end
            end
        end
    end

    assign status_value = {ready_n, err, ref_missing_flag, parity, result_channel_tag};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_LOAD_CLEARS_READY: assert property (result_load |=> !status_value[7])
        else $error("ready bit not low after a new result");
    AST_ERR_FOLLOWS_RESULT: assert property (
        result_load |=> status_value[6] == $past(result_over | ref_missing_flag | cal_fault))
        else $error("error flag wrong after a new result");
    AST_REF_MISSING_FLAG_NEEDS_ENABLE: assert property (!ref_detect_enable |=> !ref_missing_flag)
        else $error("missing reference flag set while detection disabled");
    AST_REF_MISSING_FLAG_CLAMPS: assert property (
        (result_load && ref_missing_flag) |=> data_value == 24'hFF_FFFF)
        else $error("result not clamped to ones without reference");
    AST_PARITY_ODD: assert property (
        ##1 status_value[4] == ($past(parity_check_enable) && $past(^data_value)))
        else $error("parity bit disagrees with held data");
    AST_TAG_HELD: assert property (
        !result_load |=> status_value[3:0] == $past(status_value[3:0]))
        else $error("channel tag moved without a new result");
    AST_CAL_ERR: assert property ((cal_active && ref_below) |=> status_value[6])
        else $error("error flag not set on calibration with bad reference");
endmodule

//--- sim/host_model.sv
// serial host model driving the converter's control port
`timescale 1ns/1ps
module host_model (
    input  wire logic clock,
    input  wire logic dout,
    output logic      sclk_pin,
    output logic      cs_n_pin,
    output logic      din_pin
);
    // idle levels: clock high, select off, data high
    initial begin
        sclk_pin = 1'b1;
        cs_n_pin = 1'b1;
        din_pin  = 1'b1;
    end
    // ------------------------------------------------------------
    // one frame: command byte then n data bits, msb first
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                         output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd << (24 - n)};
        rd = 24'h00_0000;
        @(posedge clock);
        cs_n_pin <= 1'b0;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 8 + n; i++) begin
            sclk_pin <= 1'b0;
            din_pin  <= sh[31];
            sh = sh << 1;
            repeat (6) @(posedge clock);
            if (i >= 8) rd = {rd[22:0], dout};
            sclk_pin <= 1'b1;
            repeat (6) @(posedge clock);
        end
        cs_n_pin <= 1'b1;
        din_pin  <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench of the status and mode register block
`timescale 1ns/1ps
module tb_top;
    logic        clock, resetn, sclk_pin, cs_n_pin, din_pin, sync_n_pin, result_load, dout;
    logic        result_over, pre_update_warn, ref_below, ref_detect_enable, dout_oe_n;
    logic        modulator_reset, ref_missing_flag;
    logic        cal_active, cal_system, cal_input_out_of_range;
    logic [3:0]  result_channel;
    logic [7:0]  status_value;
    logic [23:0] result_data, mode_value, rd;
    int          err_total, checks, resets_seen;
    adc_status_and_mode_regs u_adc_status_and_mode_regs (
        .clock(clock), .resetn(resetn), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
        .din_pin(din_pin), .sync_n_pin(sync_n_pin), .result_load(result_load),
        .result_data(result_data), .result_over(result_over), .result_channel(result_channel),
        .pre_update_warn(pre_update_warn), .ref_below(ref_below),
        .ref_detect_enable(ref_detect_enable), .cal_active(cal_active), .cal_system(cal_system),
        .cal_input_out_of_range(cal_input_out_of_range), .dout(dout), .dout_oe_n(dout_oe_n),
        .mode_value(mode_value), .status_value(status_value),
        .modulator_reset(modulator_reset), .ref_missing_flag(ref_missing_flag));
    host_model u_host_model (.clock(clock), .dout(dout), .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin), .din_pin(din_pin));
    // clock, restart pulse count and watchdog
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (modulator_reset === 1'b1) resets_seen++;
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run;
    end
    // ------------------------------------------------------------
    // compare, result load and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [23:0] d, input logic ov, input logic [3:0] ch);
        @(posedge clock);
        result_load    <= 1'b1;
        result_data    <= d;
        result_over    <= ov;
        result_channel <= ch;
        @(posedge clock);
        result_load <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic complete_run;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence of register accesses and converter events
    initial begin
        {resetn, result_load, result_data, result_over, result_channel} = '0;
        {pre_update_warn, ref_below, ref_detect_enable, sync_n_pin} = 4'h1;
        {cal_active, cal_system, cal_input_out_of_range} = 3'h0;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(posedge clock);
        chk(status_value, 24'h80);
        chk(mode_value, 24'h08_0060);
        chk(dout_oe_n, 1'b1);
        u_host_model.frame(8'h40, 8, 24'h0, rd); chk(rd, 24'h80);
        u_host_model.frame(8'hA0, 8, 24'h0, rd); chk(rd, 24'hC0);
        load(24'h7, 1'b1, 4'hA); chk(status_value, 24'h4A);
        chk(dout, 1'b0);
        u_host_model.frame(8'h08, 24, 24'h7FFF, rd); chk(mode_value, 24'h3FFF);
        chk(status_value[7], 1'b1); chk(resets_seen, 1);
        u_host_model.frame(8'h48, 24, 24'h0, rd); chk(rd, 24'h3FFF);
        load(24'h3, 1'b0, 4'h2); chk(status_value, 24'h02);
        u_host_model.frame(8'h00, 0, 24'h0, rd); chk(status_value, 24'h02);
        u_host_model.frame(8'h58, 24, 24'h0, rd); chk(rd, 24'h3);
        chk(status_value[7], 1'b1);
        load(24'h7, 1'b0, 4'h5); chk(status_value, 24'h15);
        pre_update_warn <= 1'b1;
        @(posedge clock);
        pre_update_warn <= 1'b0;
        repeat (3) @(posedge clock);
        chk(status_value[7], 1'b1);
        load(24'h7, 1'b0, 4'h5);
        sync_n_pin <= 1'b0;
        repeat (6) @(posedge clock);
        chk(status_value[7], 1'b1);
        sync_n_pin <= 1'b1;
        ref_detect_enable <= 1'b1;
        ref_below <= 1'b1;
        repeat (4) @(posedge clock);
        chk(ref_missing_flag, 1'b1); chk(status_value[5], 1'b1);
        load(24'h7, 1'b0, 4'h3); chk(status_value, 24'h63);
        u_host_model.frame(8'h58, 24, 24'h0, rd); chk(rd, 24'hFF_FFFF);
        ref_detect_enable <= 1'b0;
        repeat (4) @(posedge clock);
        chk(ref_missing_flag, 1'b0);
        load(24'h1, 1'b0, 4'h1); chk(status_value[6], 1'b0);
        cal_active <= 1'b1;
        repeat (3) @(posedge clock);
        chk(status_value[6], 1'b1);
        {ref_below, cal_system} <= 2'h1;
        load(24'h1, 1'b0, 4'h1); chk(status_value[6], 1'b0);
        cal_input_out_of_range <= 1'b1;
        repeat (3) @(posedge clock);
        chk(status_value[6], 1'b1);
        {cal_active, cal_system, cal_input_out_of_range} <= 3'h0;
        u_host_model.frame(8'h08, 24, 24'h90_0060, rd);
        load(24'h12_3456, 1'b0, 4'h9); chk(status_value, 24'h89);
        u_host_model.frame(8'h58, 32, 24'h0, rd); chk(rd, 24'h34_5689);
        complete_run;
    end
endmodule
